// ### common/twr_cfg.svh
`ifndef TWR_CFG_SVH
`define TWR_CFG_SVH
// apb byte offsets
`define TWR_OFS_CTRL     12'h000
`define TWR_OFS_STAT     12'h004
`define TWR_OFS_MASK     12'h008
`define TWR_OFS_LAST     12'h00C
`define TWR_OFS_MEM      12'h100
// control bits
`define TWR_CTRL_UMI     0
`define TWR_CTRL_BCSEL   3
`define TWR_CTRL_BUSY    4
`define TWR_CTRL_RST     32'h0000_0000
// record slots
`define TWR_SLOT_MIW     2'h0
`define TWR_SLOT_TAG     2'h1
`define TWR_SLOT_DAT     2'h2
// mode codes
`define TWR_MC_DATA_MIN  5'h10
`define TWR_MC_LASTCMD   5'h12
`define TWR_MC_BITWORD   5'h13
`define TWR_MC_UND_A     5'h11
`define TWR_MC_UND_B     5'h14
`define TWR_MC_UND_C     5'h15
`endif

// ### common/twr_pkg.sv
package twr_pkg;
    // command handed over at message start
    typedef struct packed {
        logic [15:0] ptr;
        logic [4:0]  mode_code_field;
        logic        bus_identity_bit;
        logic        illegal_entry;
        logic        force_busy_control;
    } twr_cmd_t;
    // error summary handed over at completion
    typedef struct packed {
        logic        gap_seen;
        logic        broadcast;
        logic        extra_words;
    } twr_done_t;
    // transmit mode information word
    typedef struct packed {
        logic [1:0]  unused_hi;
        logic        gap_or_broadcast_flag;
        logic        word_count_error;
        logic        unused_11;
        logic        message_error_flag;
        logic        was_busy_flag;
        logic        illegal_command_flag;
        logic [1:0]  unused_lo;
        logic        bus_identity_bit;
        logic [4:0]  mode_code_field;
    } twr_miw_t;
    typedef enum logic [2:0] {
        ST_IDLE, ST_FETCH, ST_WAIT, ST_MIW, ST_TAG, ST_DAT
    } twr_state_t;
endpackage

// ### hdl/twr_writer.sv
`timescale 1ns/1ps
`include "twr_cfg.svh"
module twr_writer
    import twr_pkg::*;
#(
    parameter int AW = 6
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cmd_valid,
    input  wire twr_cmd_t    cmd,
    input  wire logic        done_valid,
    input  wire twr_done_t   done,
    input  wire logic [15:0] time_tag,
    input  wire logic [15:0] last_cmd_word,
    input  wire logic [15:0] bit_word,
    output logic             tx_valid,
    output logic      [15:0] tx_word,
    output logic             busy,
    output logic             irq
);

    // record index: pointer plus slot, wrapped to memory depth
    function automatic logic [AW-1:0] rec_idx(input logic [15:0] p,
                                              input logic [1:0]  s);
        return p[AW-1:0] + AW'(s);
    endfunction

    //////////////////////////////////////////////////////////////////////
    // state
    twr_state_t        st_q, st_d;
    twr_cmd_t          cmd_q;
    twr_done_t         done_q;
    logic [15:0]       tag_q;
    logic [15:0]       sent_q, sent_d;
    logic              send_q;
    logic [15:0]       mem [2**AW];
    logic [31:0]       ctrl_q;
    logic [1:0]        stat_q, mask_q;
    logic [15:0]       last_q;
    logic [31:0]       prdata_q, prdata_d;
    logic              pready_q, pslverr_q, pslverr_d;
    logic              tx_valid_q, irq_q;
    logic [15:0]       tx_word_q;

    //////////////////////////////////////////////////////////////////////
    // command classification
    wire logic [4:0] mc        = cmd_q.mode_code_field;
    wire logic       has_data  = mc >= `TWR_MC_DATA_MIN;
    wire logic       gen_data  = (mc == `TWR_MC_LASTCMD) | (mc == `TWR_MC_BITWORD);
    wire logic       undef_mc  = (mc == `TWR_MC_UND_A) | (mc == `TWR_MC_UND_B)
                               | (mc == `TWR_MC_UND_C);
    wire logic       umi       = ctrl_q[`TWR_CTRL_UMI];
    wire logic       bc_sel    = ctrl_q[`TWR_CTRL_BCSEL];
    wire logic       was_busy  = ctrl_q[`TWR_CTRL_BUSY] | cmd_q.force_busy_control;
    // undefined codes answer in form only when legal and allowed
    wire logic       undef_ok  = ~undef_mc | ~umi;
    // busy or illegal answers carry no data word
    wire logic       may_send  = has_data & ~was_busy
                               & ~cmd_q.illegal_entry & undef_ok;
    wire logic [15:0] gen_word = (mc == `TWR_MC_LASTCMD) ? last_cmd_word : bit_word;

    //////////////////////////////////////////////////////////////////////
    // information word assembly
    twr_miw_t miw;
    wire logic gap_err = done_q.gap_seen & ~bc_sel;
    always_comb begin
        miw = '0;
        miw.gap_or_broadcast_flag = bc_sel ? done_q.broadcast
                                           : done_q.gap_seen;
        miw.word_count_error      = done_q.extra_words;
        miw.message_error_flag    = done_q.extra_words | gap_err;
        miw.was_busy_flag         = was_busy;
        miw.illegal_command_flag  = cmd_q.illegal_entry;
        miw.bus_identity_bit      = cmd_q.bus_identity_bit;
        miw.mode_code_field       = mc;
    end

    //////////////////////////////////////////////////////////////////////
    // record sequencer
    always_comb begin
        st_d   = st_q;
        sent_d = sent_q;
        unique case (st_q)
            ST_IDLE: if (cmd_valid) begin
                st_d = ST_FETCH;
            end
            ST_FETCH: begin
                st_d = ST_WAIT;
                if (may_send) begin
                    // generated codes bypass memory
                    sent_d = gen_data ? gen_word
                           : mem[rec_idx(cmd_q.ptr, `TWR_SLOT_DAT)];
                end
            end
            ST_WAIT: if (done_valid) begin
                st_d = ST_MIW;
            end
            ST_MIW: st_d = ST_TAG;
            // two-word record ends at tag unless a generated word was sent
            ST_TAG: st_d = (send_q & gen_data) ? ST_DAT : ST_IDLE;
            ST_DAT: st_d = ST_IDLE;
        endcase
    end

    // device write port
    wire logic          dev_wr  = (st_q == ST_MIW) | (st_q == ST_TAG)
                                | (st_q == ST_DAT);
    wire logic          dev_nxt = (st_d == ST_MIW) | (st_d == ST_TAG)
                                | (st_d == ST_DAT);
    wire logic [1:0]    dev_slot = (st_q == ST_MIW) ? `TWR_SLOT_MIW
                                 : (st_q == ST_TAG) ? `TWR_SLOT_TAG
                                 : `TWR_SLOT_DAT;
    wire logic [AW-1:0] dev_idx  = rec_idx(cmd_q.ptr, dev_slot);
    wire logic [15:0]   dev_dat  = (st_q == ST_MIW) ? miw
                                 : (st_q == ST_TAG) ? tag_q
                                 : sent_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q   <= ST_IDLE;
            cmd_q  <= '0;
            done_q <= '0;
            tag_q  <= 16'h0000;
            sent_q <= 16'h0000;
            send_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            sent_q <= sent_d;
            if (st_q == ST_IDLE && cmd_valid) begin
                cmd_q <= cmd;
            end
            if (st_q == ST_FETCH) begin
                send_q <= may_send;
            end
            if (st_q == ST_WAIT && done_valid) begin
                done_q <= done;
                tag_q  <= time_tag;
            end
        end
    end

    // data word goes out one cycle after fetch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_valid_q <= 1'b0;
            tx_word_q  <= 16'h0000;
        end else begin
            tx_valid_q <= (st_q == ST_FETCH) & may_send;
            if (st_q == ST_FETCH && may_send) begin
                tx_word_q <= sent_d;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    // apb decode
    wire logic       acc      = psel & penable;
    wire logic       commit   = acc & pready_q;
    wire logic       is_mem   = paddr[11:8] == `TWR_OFS_MEM >> 8;
    wire logic       is_ctrl  = paddr == `TWR_OFS_CTRL;
    wire logic       is_stat  = paddr == `TWR_OFS_STAT;
    wire logic       is_mask  = paddr == `TWR_OFS_MASK;
    wire logic       is_last  = paddr == `TWR_OFS_LAST;
    wire logic       mapped   = is_mem | is_ctrl | is_stat | is_mask | is_last;
    wire logic [AW-1:0] m_idx = paddr[AW+1:2];
    // access holds off while the sequencer owns the memory
    wire logic       pready_d = acc & ~pready_q & ~dev_nxt;
    wire logic       apb_mw   = commit & pwrite & is_mem & ~dev_wr;

    always_comb begin
        prdata_d = 32'h0000_0000;
        if (is_mem) begin
            prdata_d = {16'h0000, mem[m_idx]};
        end else if (is_ctrl) begin
            prdata_d = ctrl_q;
        end else if (is_stat) begin
            prdata_d = {30'h0, stat_q};
        end else if (is_mask) begin
            prdata_d = {30'h0, mask_q};
        end else if (is_last) begin
            prdata_d = {16'h0000, last_q};
        end
        pslverr_d = ~mapped;
    end

    // record memory, one write port shared by sequencer and host
    always_ff @(posedge pclk) begin
        if (dev_wr) begin
            mem[dev_idx] <= dev_dat;
        end else if (apb_mw) begin
            mem[m_idx] <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= pready_d;
            pslverr_q <= pready_d & pslverr_d;
            if (pready_d && !pwrite) begin
                prdata_q <= prdata_d;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    // control, last info word, interrupts
    wire logic [1:0] ev_set = {(st_q == ST_MIW) & (miw.message_error_flag
                                | cmd_q.illegal_entry | was_busy),
                               st_q == ST_DAT | (st_q == ST_TAG & st_d == ST_IDLE)};
    // a read clears only the bits it returned, so an event in the read's last cycle survives
    wire logic [1:0] ev_clr = {2{commit & ~pwrite & is_stat}} & prdata_q[1:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `TWR_CTRL_RST;
            mask_q <= 2'h0;
            stat_q <= 2'h0;
            last_q <= 16'h0000;
            irq_q  <= 1'b0;
        end else begin
            if (commit && pwrite && is_ctrl) begin
                ctrl_q <= pwdata;
            end
            if (commit && pwrite && is_mask) begin
                mask_q <= pwdata[1:0];
            end
            stat_q <= (stat_q & ~ev_clr) | ev_set;      // set wins
            if (st_q == ST_MIW) begin
                last_q <= miw;
            end
            irq_q  <= |(((stat_q & ~ev_clr) | ev_set) & mask_q);
        end
    end

    assign prdata   = prdata_q;
    assign pready   = pready_q;
    assign pslverr  = pslverr_q;
    assign tx_valid = tx_valid_q;
    assign tx_word  = tx_word_q;
    assign irq      = irq_q;
    assign busy     = send_q;

    //////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_miw_slot_ptr: assert property (
        st_q == ST_MIW |-> dev_idx == cmd_q.ptr[AW-1:0]
        ##1 dev_idx == rec_idx(cmd_q.ptr, `TWR_SLOT_TAG))
        else $error("info word or tag slot wrong");

    chk_gen_store: assert property (
        st_q == ST_DAT |-> gen_data && send_q && dev_dat == tx_word_q
        && dev_idx == rec_idx(cmd_q.ptr, `TWR_SLOT_DAT))
        else $error("generated word not stored at slot two");

    chk_gen_send: assert property (
        st_q == ST_FETCH && may_send && mc == `TWR_MC_BITWORD
        |=> tx_valid_q && tx_word_q == $past(bit_word))
        else $error("bit word not sent");

    chk_after_done: assert property (
        st_q == ST_MIW |-> $past(st_q) == ST_WAIT && $past(done_valid))
        else $error("record written before completion");

    chk_two_word: assert property (
        st_q == ST_TAG && !has_data |=> st_q == ST_IDLE)
        else $error("no-data record longer than two words");

    chk_busy_nodata: assert property (
        tx_valid_q |-> !was_busy && !cmd_q.illegal_entry)
        else $error("data sent on busy or illegal command");

    chk_undef_form: assert property (
        st_q == ST_FETCH && undef_mc && umi && !gen_data |=> !tx_valid_q)
        else $error("undefined code answered while forbidden");

    chk_miw_fields: assert property (
        st_q == ST_MIW |-> dev_dat[4:0] == cmd_q.mode_code_field
        && dev_dat[5] == cmd_q.bus_identity_bit && dev_dat[15:14] == 2'h0
        && dev_dat[11] == 1'b0 && dev_dat[7:6] == 2'h0)
        else $error("info word fields wrong");

    chk_err_bits: assert property (
        st_q == ST_MIW |-> dev_dat[12] == done_q.extra_words
        && dev_dat[13] == (bc_sel ? done_q.broadcast : done_q.gap_seen)
        && dev_dat[10] == (dev_dat[12] | (dev_dat[13] & ~bc_sel)))
        else $error("error flags wrong");

    chk_irq_level: assert property (
        ##1 irq_q == |($past(stat_q & ~ev_clr | ev_set) & $past(mask_q)))
        else $error("interrupt level wrong");

    chk_tx_pulse: assert property (
        tx_valid_q |=> !tx_valid_q)
        else $error("data word strobe longer than one cycle");

    chk_pready_pulse: assert property (
        pready_q |=> !pready_q)
        else $error("ready held for more than one cycle");

    chk_apb_hold: assert property (
        pready_q |-> $past(acc) && !$past(pready_q))
        else $error("ready without an access phase");

    chk_no_clash: assert property (
        commit |-> !dev_wr)
        else $error("host access committed during record write");

    chk_slverr_unmapped: assert property (
        pslverr_q |-> pready_q && !$past(mapped))
        else $error("error response on a mapped address");

    chk_stat_sticky: assert property (
        ev_set != 2'h0 |=> (stat_q & $past(ev_set)) == $past(ev_set))
        else $error("status event lost");

    chk_rd_clear: assert property (
        commit && !pwrite && is_stat && ev_set == 2'h0
        |=> (stat_q & prdata_q[1:0]) == 2'h0)
        else $error("status bits not cleared by read");

    chk_cmd_hold: assert property (
        st_q != ST_IDLE |=> $stable(cmd_q))
        else $error("command changed during a record");

    chk_host_slot: assert property (
        st_q == ST_TAG && !(send_q && gen_data) |=> !dev_wr)
        else $error("device wrote a host-loaded data word");

endmodule

// ### sim/twr_bc_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// bus controller side: issues one mode command, then completion after dly cycles
module twr_bc_model
    import twr_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        go,
    input  wire logic [3:0]  dly,
    input  wire twr_cmd_t    cmd_in,
    input  wire twr_done_t   done_in,
    input  wire logic [15:0] tag_in,
    output logic             cmd_valid,
    output twr_cmd_t         cmd,
    output logic             done_valid,
    output twr_done_t        done,
    output logic      [15:0] time_tag,
    output logic      [15:0] last_cmd_word,
    output logic      [15:0] bit_word
);
    logic [3:0] cnt_q;

    // sources for the two internally generated data words
    assign last_cmd_word = 16'hA5C3;
    assign bit_word      = 16'h5A3C;

    // command pulse, completion delay, and scrambled lines once released
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_valid  <= 1'b0;
            done_valid <= 1'b0;
            cnt_q      <= 4'h0;
            cmd        <= '0;
            done       <= '0;
            time_tag   <= 16'h0000;
        end else begin
            cmd_valid  <= go;
            done_valid <= (cnt_q == 4'h1);
            if (go) begin
                cmd   <= cmd_in;
                cnt_q <= dly;
            end else if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end
            if (cnt_q == 4'h1) begin
                done     <= done_in;
                time_tag <= tag_in;
            end else if (done_valid) begin
                done     <= ~done;     // stale after sampling
                time_tag <= ~time_tag;
            end
        end
    end
endmodule

// ### sim/tx_mode_cmd_record_writer_tb.sv
`timescale 1ns/1ps
module tx_mode_cmd_record_writer_tb
    import twr_pkg::*;
;
    typedef struct {
        logic [31:0] ctrl;
        logic [4:0]  code;
        logic [15:0] ptr;
        logic [5:0]  fl;
        logic [15:0] pre;
        logic        tx;
        logic [15:0] dat;
        logic [15:0] miw;
    } twr_row_t;
    logic        pclk = 1'b0, presetn = 1'b0, go = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, cmd_valid, done_valid, tx_valid, busy, irq, se;
    logic [15:0] time_tag, last_cmd_word, bit_word, tx_word, tx_seen, tag_in = 16'h0;
    logic [3:0]  dly = 4'h4;
    twr_cmd_t    cmd, cmd_in = '0;
    twr_done_t   done, done_in = '0;
    int          err_count = 0, n_checks = 0, tx_n = 0;
    twr_row_t    rows [10];

    // fl = {bus b, illegal, force busy, gap, broadcast, extra words}
    initial rows = '{
        '{32'h00, 5'h10, 16'd8,  6'h00, 16'h1234, 1'b1, 16'h1234, 16'h0010},
        '{32'h00, 5'h12, 16'd16, 6'h20, 16'h0000, 1'b1, 16'hA5C3, 16'h0032},
        '{32'h00, 5'h13, 16'd24, 6'h01, 16'h0000, 1'b1, 16'h5A3C, 16'h1413},
        '{32'h00, 5'h05, 16'd32, 6'h06, 16'hBEEF, 1'b0, 16'hBEEF, 16'h2405},
        '{32'h01, 5'h11, 16'd40, 6'h00, 16'h0BAD, 1'b0, 16'h0BAD, 16'h0011},
        '{32'h00, 5'h14, 16'd48, 6'h00, 16'h7E81, 1'b1, 16'h7E81, 16'h0014},
        '{32'h00, 5'h10, 16'd8,  6'h08, 16'h1234, 1'b0, 16'h1234, 16'h0210},
        '{32'h00, 5'h15, 16'd56, 6'h10, 16'h3C3C, 1'b0, 16'h3C3C, 16'h0115},
        '{32'h08, 5'h1F, 16'd0,  6'h06, 16'h0F0F, 1'b1, 16'h0F0F, 16'h201F},
        '{32'h10, 5'h12, 16'd4,  6'h00, 16'hCAFE, 1'b0, 16'hCAFE, 16'h0212}};

    always #5 pclk = ~pclk;

    // record each word handed to the transmitter
    always @(posedge pclk) if (tx_valid === 1'b1) begin
        tx_n++;
        tx_seen = tx_word;
    end

    twr_writer #(.AW(6)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid),
        .cmd(cmd), .done_valid(done_valid), .done(done), .time_tag(time_tag),
        .last_cmd_word(last_cmd_word), .bit_word(bit_word), .tx_valid(tx_valid),
        .tx_word(tx_word), .busy(busy), .irq(irq));

    twr_bc_model u_bc (.pclk(pclk), .presetn(presetn), .go(go), .dly(dly),
        .cmd_in(cmd_in), .done_in(done_in), .tag_in(tag_in), .cmd_valid(cmd_valid),
        .cmd(cmd), .done_valid(done_valid), .done(done), .time_tag(time_tag),
        .last_cmd_word(last_cmd_word), .bit_word(bit_word));

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer: setup, access held until pready, then one idle edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (pready !== 1'b1) begin check("apb ready", 1, 0); test_done(); end
        @(posedge pclk);
    endtask

    task automatic rd32(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        check(what, exp, rd);
        check({what, " err"}, 32'h0, {31'h0, se});
    endtask

    function automatic logic [11:0] mem_a(input logic [15:0] p, input int k);
        return 12'h100 + {4'h0, p[5:0] + k[5:0], 2'b00};
    endfunction

    // one command: preload, issue, wait for interrupt, read record back
    task automatic run_row(input int i, input logic m);
        twr_row_t r;
        int n;
        r = rows[i];
        apb(1'b1, 12'h000, r.ctrl);
        apb(1'b1, mem_a(r.ptr, 2), {16'h0, r.pre});
        tx_n = 0;
        cmd_in <= '{r.ptr, r.code, r.fl[5], r.fl[4], r.fl[3]};
        done_in <= '{r.fl[2], r.fl[1], r.fl[0]};
        tag_in <= 16'h1000 + i[15:0];
        dly <= i[0] ? 4'hB : 4'h4;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        n = 0;
        while (irq !== 1'b1 && n < 40) begin @(posedge pclk); n++; end
        check("irq", {31'h0, m}, {31'h0, irq});
        if (m && irq !== 1'b1) test_done();
        check("tx count", {31'h0, r.tx}, tx_n);
        if (r.tx) check("tx word", {16'h0, r.dat}, {16'h0, tx_seen});
        check("busy", {31'h0, r.tx}, {31'h0, busy});
        rd32(mem_a(r.ptr, 0), {16'h0, r.miw}, "info word");
        rd32(mem_a(r.ptr, 1), 32'h1000 + i, "time tag");
        rd32(mem_a(r.ptr, 2), {16'h0, r.dat}, "data word");
        rd32(12'h00C, {16'h0, r.miw}, "last info");
        rd32(12'h004, {30'h0, r.miw[10] | r.miw[9] | r.miw[8], 1'b1}, "status");
        repeat (2) @(posedge pclk);
        check("irq cleared", 0, {31'h0, irq});
        $display("test row %0d done", i);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        check("reset outputs", 0, {28'h0, irq, tx_valid, busy, pready});
        @(posedge pclk);
        rd32(12'h000, 32'h0, "ctrl reset");
        $display("test reset done");
        apb(1'b1, 12'h008, 32'h3);
        for (int i = 0; i < 10; i++) run_row(i, 1'b1);
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped read err", 1, {31'h0, se});
        check("unmapped read data", 0, rd);
        apb(1'b1, 12'h200, 32'hFFFF);
        check("unmapped write err", 1, {31'h0, se});
        rd32(12'h100, 32'h0000_201F, "unmapped write ignored");
        $display("test unmapped done");
        apb(1'b1, 12'h008, 32'h0);
        run_row(0, 1'b0);
        rd32(12'h004, 32'h0, "status after clear");
        $display("test masked done");
        // reset in mid-run brings registers and outputs back to idle values
        apb(1'b1, 12'h000, 32'h19);
        apb(1'b1, 12'h008, 32'h3);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check("mid reset outputs", 0, {28'h0, irq, tx_valid, busy, pready});
        presetn <= 1'b1;
        @(posedge pclk);
        rd32(12'h000, 32'h0, "ctrl after reset");
        rd32(12'h008, 32'h0, "mask after reset");
        $display("test mid reset done");
        test_done();
    end

    // overall limit on run length
    initial begin
        repeat (100000) @(posedge pclk);
        check("run length", 0, 1);
        test_done();
    end
endmodule
